// >>> core/cmp_ctrl_device.sv
// Dual comparator control: modes, polarity, change detection and Timer1 gate.
// What this block does
// - Output change sets that comparator's flag.
// - Control read reloads the reference latch.
// - Q1 latch samples output; differs means mismatch.
// - Mismatch holds flag until read or return.
// - Control write also reloads the reference.
// - Flag clears by writing zero; one sets.
// - Request needs individual, peripheral, global enables.
// - Clearing flag during mismatch does not stick.
// - Change at read start may miss flag.
// - Runs in sleep; modes 000/111 switch off.
// - Change wakes with individual and peripheral enables.
// - Reset restores both configuration registers.
// - Output bit follows inputs, inverted by invert.
// - Mode field selects off or comparator configurations.
// - Gate select zero routes comparator 2 to Timer1.
// - Sync bit latches comparator 2 on falling edge.
// - Latch follows prescaled Timer1 clock.
// - Software sets sync when comparator gates Timer1.
// - Software waits settle time before enabling interrupts.
// - Upper six gate register bits read zero.
// - Output pins driven only in mode 110.
// - Input switch acts only in modes 001/010/101.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_device (
  // Clock and reset.
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Bus and Timer1 side.
  cmp_link_if.device      link,
  // Raw analog comparator results (non-inverting above inverting).
  input  wire logic [1:0] i_cmp_raw,
  // Dedicated Timer1 gate pin.
  input  wire logic       i_timer1_gate_pin,
  // Pin-facing outputs.
  output logic      [1:0] o_cmp_pin,
  output logic      [1:0] o_cmp_pin_oe,
  output logic            o_cmp_power,
  output logic            o_pins_digital,
  output logic            o_input_switch
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [5:0] mode_control_reg;
  logic [1:0] gate_sync_reg;
  logic [1:0] flag_reg;
  logic [1:0] enable_reg;
  logic       peripheral_irq_enable_reg;
  logic       gie_reg;
  logic [1:0] ref_latch_reg;
  logic [1:0] q1_latch_reg;
  logic [1:0] mismatch_reg;
  logic [1:0] q_phase_reg;
  logic       t1_clk_prev_reg;
  logic       c2_sync_reg;
  logic       ack_reg;
  logic [7:0] rdat_reg;
  logic [1:0] cmp_out;
  logic       cmp_on;
  logic [2:0] mode;
  logic       q1;
  logic       bus_req;
  logic       ctl_access;
  logic       flag_write;
  logic       t1_fall;

  assign mode    = mode_control_reg[2:0];
  assign bus_req = link.cyc && link.stb && !ack_reg;
  assign ctl_access = bus_req && (link.adr == cmp_ctrl_pkg::ADDR_MODE_CONTROL);
  assign flag_write = bus_req && link.we && (link.adr == cmp_ctrl_pkg::ADDR_FLAGS);
  assign q1      = (q_phase_reg == 2'h0);
  assign t1_fall = t1_clk_prev_reg && !link.timer1_clk;

  // Comparators are off in either off mode; outputs then read low.
  assign cmp_on  = (mode != cmp_ctrl_pkg::MODE_OFF_ANALOG) &&
                   (mode != cmp_ctrl_pkg::MODE_OFF_DIGITAL);
  // Output polarity per comparator.
  assign cmp_out[0] = cmp_on && (i_cmp_raw[0] ^ mode_control_reg[cmp_ctrl_pkg::INV1_BIT]);
  assign cmp_out[1] = cmp_on && (i_cmp_raw[1] ^ mode_control_reg[cmp_ctrl_pkg::INV2_BIT]);

  // Phase counter producing the Q1 pulse.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q_phase_reg <= 2'h0;
    end else begin
      q_phase_reg <= q_phase_reg + 2'h1;
    end
  end

  // Bus acknowledge, one cycle after the request is seen.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Configuration writes.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_control_reg <= cmp_ctrl_pkg::MODE_CONTROL_RESET[5:0];
      gate_sync_reg    <= cmp_ctrl_pkg::GATE_SYNC_RESET;
      enable_reg       <= 2'h0;
      peripheral_irq_enable_reg         <= 1'b0;
      gie_reg          <= 1'b0;
    end else if (bus_req && link.we) begin
      case (link.adr)
        cmp_ctrl_pkg::ADDR_MODE_CONTROL: mode_control_reg <= link.wdat[5:0];
        cmp_ctrl_pkg::ADDR_GATE_SYNC:    gate_sync_reg    <= link.wdat[1:0];
        cmp_ctrl_pkg::ADDR_ENABLES: begin
          enable_reg <= link.wdat[1:0];
          peripheral_irq_enable_reg   <= link.wdat[cmp_ctrl_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
          gie_reg    <= link.wdat[cmp_ctrl_pkg::GIE_BIT];
        end
        default: ;
      endcase
    end
  end

  // Reference latch reloads on any control read or write.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ref_latch_reg <= 2'h0;
    end else if (ctl_access) begin
      ref_latch_reg <= cmp_out;
    end
  end

  // Q1 sampling latch.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q1_latch_reg <= 2'h0;
    end else if (q1) begin
      q1_latch_reg <= cmp_out;
    end
  end

  // Registered mismatch; a read in progress masks it, so a change then may be lost.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mismatch_reg <= 2'h0;
    end else if (ctl_access) begin
      mismatch_reg <= 2'h0;
    end else begin
      mismatch_reg <= q1_latch_reg ^ ref_latch_reg;
    end
  end

  // Change flags: mismatch sets and wins over a software clear.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flag_reg <= 2'h0;
    end else if (flag_write) begin
      flag_reg <= link.wdat[1:0] | mismatch_reg;
    end else begin
      flag_reg <= flag_reg | mismatch_reg;
    end
  end

  // Read data multiplexer; unmapped addresses read zero.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdat_reg <= 8'h00;
    end else begin
      case (link.adr)
        cmp_ctrl_pkg::ADDR_MODE_CONTROL: rdat_reg <= {cmp_out[1], cmp_out[0], mode_control_reg};
        cmp_ctrl_pkg::ADDR_GATE_SYNC:    rdat_reg <= {6'h00, gate_sync_reg};
        cmp_ctrl_pkg::ADDR_FLAGS:        rdat_reg <= {6'h00, flag_reg};
        cmp_ctrl_pkg::ADDR_ENABLES:      rdat_reg <= {4'h0, gie_reg, peripheral_irq_enable_reg, enable_reg};
        default:                         rdat_reg <= 8'h00;
      endcase
    end
  end

  // Comparator 2 latch on falling edge of the prescaled Timer1 clock.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      t1_clk_prev_reg <= 1'b0;
      c2_sync_reg     <= 1'b0;
    end else begin
      t1_clk_prev_reg <= link.timer1_clk;
      if (t1_fall) begin
        c2_sync_reg <= cmp_out[1];
      end
    end
  end

  // Gate, interrupt, wake and pin outputs.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      link.timer1_gate <= 1'b0;
      link.irq         <= 1'b0;
      link.wake        <= 1'b0;
      o_cmp_pin        <= 2'h0;
      o_cmp_pin_oe     <= 2'h0;
      o_cmp_power      <= 1'b0;
      o_pins_digital   <= 1'b0;
      o_input_switch   <= 1'b0;
    end else begin
      if (gate_sync_reg[cmp_ctrl_pkg::GSS_BIT]) begin
        link.timer1_gate <= i_timer1_gate_pin;
      end else if (gate_sync_reg[cmp_ctrl_pkg::SYNC_BIT]) begin
        link.timer1_gate <= c2_sync_reg;
      end else begin
        link.timer1_gate <= cmp_out[1];
      end
      link.irq  <= |(flag_reg & enable_reg) && peripheral_irq_enable_reg && gie_reg;
      link.wake <= |(flag_reg & enable_reg) && peripheral_irq_enable_reg;
      o_cmp_pin <= cmp_out;
      o_cmp_pin_oe <= {2{mode == cmp_ctrl_pkg::MODE_PIN_OUTPUTS}};
      o_cmp_power <= cmp_on;
      o_pins_digital <= (mode == cmp_ctrl_pkg::MODE_OFF_DIGITAL);
      o_input_switch <= mode_control_reg[cmp_ctrl_pkg::SWITCH_BIT] &&
                        ((mode == cmp_ctrl_pkg::MODE_C1_SWITCHED) ||
                         (mode == cmp_ctrl_pkg::MODE_TWO_SWITCHED) ||
                         (mode == cmp_ctrl_pkg::MODE_ONE_INDEP));
    end
  end

  assign link.ack  = ack_reg;
  assign link.rdat = rdat_reg;
endmodule : cmp_ctrl_device
`default_nettype wire

// >>> core/cmp_ctrl_pkg.sv
// Package of shared constants for the dual comparator control block.
package cmp_ctrl_pkg;
  // ************************************************************
  // Wishbone register map (byte addresses, one word per register)
  // ************************************************************
  localparam logic [3:0] ADDR_MODE_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_GATE_SYNC    = 4'h4;
  localparam logic [3:0] ADDR_FLAGS        = 4'h8;
  localparam logic [3:0] ADDR_ENABLES      = 4'hc;
  localparam logic [3:0] ADDR_STATUS       = 4'h0;
  localparam logic [3:0] ADDR_HOST_ACK     = 4'h4;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int          MODE_LSB           = 0;
  localparam int          SWITCH_BIT         = 3;
  localparam int          INV1_BIT           = 4;
  localparam int          INV2_BIT           = 5;
  localparam int          OUT1_BIT           = 6;
  localparam int          OUT2_BIT           = 7;
  localparam int          SYNC_BIT           = 0;
  localparam int          GSS_BIT            = 1;
  localparam int          PERIPHERAL_IRQ_ENABLE_BIT           = 2;
  localparam int          GIE_BIT            = 3;
  localparam logic [7:0]  MODE_CONTROL_RESET = 8'h00;
  localparam logic [1:0]  GATE_SYNC_RESET    = 2'h2;

  // ************************************************************
  // Comparator modes
  // ************************************************************
  localparam logic [2:0]  MODE_OFF_ANALOG    = 3'h0;
  localparam logic [2:0]  MODE_C1_SWITCHED   = 3'h1;
  localparam logic [2:0]  MODE_TWO_SWITCHED  = 3'h2;
  localparam logic [2:0]  MODE_ONE_INDEP     = 3'h5;
  localparam logic [2:0]  MODE_PIN_OUTPUTS   = 3'h6;
  localparam logic [2:0]  MODE_OFF_DIGITAL   = 3'h7;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CLOCK_MHZ          = 100;
  localparam int          Q_PHASES           = 4;
  localparam int          BIAS_SETTLE_US     = 1;
  localparam int          BIAS_SETTLE_CYCLES = BIAS_SETTLE_US * CLOCK_MHZ;
endpackage : cmp_ctrl_pkg

// >>> core/cmp_link_if.sv
// Interface joining the comparator block and its register-bus and Timer1 partner.
`timescale 1ns/1ps
`default_nettype none
interface cmp_link_if;
  logic [3:0] adr;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic       cyc;
  logic       stb;
  logic       we;
  logic       ack;
  logic       timer1_clk;
  logic       timer1_gate;
  logic       irq;
  logic       wake;

  // The comparator block is a Wishbone slave and the Timer1 gate source.
  modport device (
    input  adr, wdat, cyc, stb, we, timer1_clk,
    output rdat, ack, timer1_gate, irq, wake
  );
  // The partner is the bus master and the Timer1 clock source.
  modport host (
    output adr, wdat, cyc, stb, we, timer1_clk,
    input  rdat, ack, timer1_gate, irq, wake
  );
endinterface : cmp_link_if
`default_nettype wire

// >>> core/cmp_ctrl_host.sv
// Partner end: bus master with command registers and Timer1 clock source.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_host #(
  parameter int T1_HALF_CYCLES = 4
) (
  // Clock and reset.
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Command interface: one request held until o_done.
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [3:0] i_adr,
  input  wire logic [7:0] i_wdat,
  output logic            o_done,
  output logic      [7:0] o_rdat,
  // Device link.
  cmp_link_if.host        link,
  // Observed device state.
  output logic            o_gate,
  output logic            o_irq,
  output logic            o_wake
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_GAP  = 2'b10
  } state_t;

  state_t     state_reg;
  logic [7:0] t1_cnt_reg;
  logic       t1_clk_reg;

  // Refuse divider settings that the eight-bit counter cannot hold.
  if (T1_HALF_CYCLES < 1 || T1_HALF_CYCLES > 255) begin : g_bad_half
    $error("T1_HALF_CYCLES out of range");
  end

  // Timer1 clock divider; sync latching relies on its falling edges.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      t1_cnt_reg <= 8'h00;
      t1_clk_reg <= 1'b0;
    end else if (t1_cnt_reg == 8'(T1_HALF_CYCLES - 1)) begin
      t1_cnt_reg <= 8'h00;
      t1_clk_reg <= !t1_clk_reg;
    end else begin
      t1_cnt_reg <= t1_cnt_reg + 8'h01;
    end
  end

  // Classic Wishbone single cycle master.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      link.cyc  <= 1'b0;
      link.stb  <= 1'b0;
      link.we   <= 1'b0;
      link.adr  <= 4'h0;
      link.wdat <= 8'h00;
      o_done    <= 1'b0;
      o_rdat    <= 8'h00;
    end else begin
      o_done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (i_req) begin
            link.cyc  <= 1'b1;
            link.stb  <= 1'b1;
            link.we   <= i_we;
            link.adr  <= i_adr;
            link.wdat <= i_wdat;
            state_reg <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (link.ack) begin
            link.cyc  <= 1'b0;
            link.stb  <= 1'b0;
            o_rdat    <= link.rdat;
            o_done    <= 1'b1;
            state_reg <= ST_GAP;
          end
        end
        ST_GAP:  state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Registered copies of the device indications.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_gate <= 1'b0;
      o_irq  <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_gate <= link.timer1_gate;
      o_irq  <= link.irq;
      o_wake <= link.wake;
    end
  end

  assign link.timer1_clk = t1_clk_reg;
endmodule : cmp_ctrl_host
`default_nettype wire

// >>> tb/cmp_link_properties.sv
// Concurrent checks on the link between the comparator block and its partner.
`timescale 1ns/1ps
`default_nettype none
module cmp_link_properties (
  // Clock and reset.
  input wire logic       i_clock,
  input wire logic       i_rst,
  // Link signals.
  input wire logic [3:0] adr,
  input wire logic [7:0] wdat,
  input wire logic [7:0] rdat,
  input wire logic       cyc,
  input wire logic       stb,
  input wire logic       we,
  input wire logic       ack,
  input wire logic       timer1_clk,
  input wire logic       timer1_gate,
  input wire logic       irq,
  input wire logic       wake
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // ************************************************************
  // Shadow registers and edge history
  // ************************************************************
  logic       take;
  logic       rd;
  logic       irq_ok;
  logic       wake_ok;
  logic       fell;
  logic [5:0] mode_reg;
  logic [1:0] gs_reg;
  logic [3:0] en_reg;
  logic [2:0] t1_reg;
  logic [2:0] hold_reg;

  // Decode bus events and the enable chains.
  assign take    = cyc && stb && !ack && we;
  assign rd      = ack && !we;
  assign irq_ok  = en_reg[3] && en_reg[2] && (en_reg[1:0] != 2'h0);
  assign wake_ok = en_reg[2] && (en_reg[1:0] != 2'h0);
  assign fell    = (t1_reg[0] && !timer1_clk) || (t1_reg[1] && !t1_reg[0])
                   || (t1_reg[2] && !t1_reg[1]);

  // Mirror the writable fields as they are written at the taking edge.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_reg <= 6'h00;
      gs_reg   <= 2'h2;
      en_reg   <= 4'h0;
    end else if (take) begin
      if (adr == cmp_ctrl_pkg::ADDR_MODE_CONTROL) mode_reg <= wdat[5:0];
      if (adr == cmp_ctrl_pkg::ADDR_GATE_SYNC) gs_reg <= wdat[1:0];
      if (adr == cmp_ctrl_pkg::ADDR_ENABLES) en_reg <= wdat[3:0];
    end
  end

  // Keep the Timer1 clock history and how long the latched gate mode has held.
  always_ff @(posedge i_clock) begin
    t1_reg <= {t1_reg[1:0], timer1_clk};
    if (i_rst || gs_reg != 2'h1) hold_reg <= 3'h0;
    else if (hold_reg != 3'h7) hold_reg <= hold_reg + 3'h1;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack stayed high for two cycles");
  ack_answer_a: assert property (cyc && stb && !ack |=> ack)
    else $error("request not answered in the next cycle");
  ack_cause_a: assert property ($rose(ack) |-> $past(cyc) && $past(stb))
    else $error("ack without a request");
  req_hold_a: assert property (cyc && !ack |=> cyc && $stable(adr) && $stable(we))
    else $error("request changed before ack");
  mode_read_a: assert property (
    rd && adr == cmp_ctrl_pkg::ADDR_MODE_CONTROL |-> rdat[5:0] == mode_reg)
    else $error("mode control read back wrong");
  gate_read_a: assert property (
    rd && adr == cmp_ctrl_pkg::ADDR_GATE_SYNC |-> rdat == {6'h00, gs_reg})
    else $error("gate sync read back wrong");
  unmapped_zero_a: assert property (rd && adr[1:0] != 2'h0 |-> rdat == 8'h00)
    else $error("unmapped read not zero");
  irq_enable_a: assert property (irq |-> irq_ok || $past(irq_ok))
    else $error("irq without its enables");
  wake_enable_a: assert property (wake |-> wake_ok || $past(wake_ok))
    else $error("wake without its enables");
  gate_edge_a: assert property (hold_reg == 3'h7 && $changed(timer1_gate) |-> fell)
    else $error("synchronised gate moved off a falling clock");

  // Main scenarios reached.
  cover property (rd && adr == cmp_ctrl_pkg::ADDR_MODE_CONTROL);
  cover property (irq);
  cover property (wake);
  cover property (hold_reg == 3'h7 && $changed(timer1_gate));
endmodule : cmp_link_properties
`default_nettype wire

// >>> tb/dual_comparator_control_tb.sv
// Self-checking bench joining both comparator ends over their link.
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_tb;
  localparam logic [3:0] A_MC = cmp_ctrl_pkg::ADDR_MODE_CONTROL;
  localparam logic [3:0] A_GS = cmp_ctrl_pkg::ADDR_GATE_SYNC;
  localparam logic [3:0] A_FL = cmp_ctrl_pkg::ADDR_FLAGS;
  localparam logic [3:0] A_EN = cmp_ctrl_pkg::ADDR_ENABLES;
  logic       i_clock;
  logic       i_rst;
  logic       req;
  logic       we;
  logic [3:0] adr;
  logic [7:0] wdat;
  logic       done;
  logic [7:0] rdat;
  logic [1:0] raw;
  logic       gpin;
  logic [1:0] pin;
  logic [1:0] oe;
  logic       power;
  logic       digital;
  logic       sw;
  logic       h_gate;
  logic       h_irq;
  logic       h_wake;
  int         mismatches;
  int         checks_done;

  // ************************************************************
  // Both ends, their link and the checker
  // ************************************************************
  cmp_link_if link ();
  cmp_ctrl_device cmp_ctrl_device_i (.i_clock(i_clock), .i_rst(i_rst), .link(link),
    .i_cmp_raw(raw), .i_timer1_gate_pin(gpin), .o_cmp_pin(pin), .o_cmp_pin_oe(oe),
    .o_cmp_power(power), .o_pins_digital(digital), .o_input_switch(sw));
  cmp_ctrl_host #(.T1_HALF_CYCLES(4)) cmp_ctrl_host_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_req(req), .i_we(we), .i_adr(adr), .i_wdat(wdat), .o_done(done), .o_rdat(rdat),
    .link(link), .o_gate(h_gate), .o_irq(h_irq), .o_wake(h_wake));
  cmp_link_properties cmp_link_properties_i (.i_clock(i_clock), .i_rst(i_rst),
    .adr(link.adr), .wdat(link.wdat), .rdat(link.rdat), .cyc(link.cyc), .stb(link.stb),
    .we(link.we), .ack(link.ack), .timer1_clk(link.timer1_clk),
    .timer1_gate(link.timer1_gate), .irq(link.irq), .wake(link.wake));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte
  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_byte(name, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit
  // One bus cycle through the partner, held until its done pulse.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_clock);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(negedge i_clock);
      n++;
    end while (done !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    q = rdat;
    @(posedge i_clock);
    req <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk_byte(name, exp, q);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask : idle
  task automatic set_raw(input logic [1:0] v);
    @(posedge i_clock);
    raw <= v;
  endtask : set_raw

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_modes();
    rd("reset mode", A_MC, 8'h00);
    rd("reset gate", A_GS, 8'h02);
    rd("unmapped", 4'h2, 8'h00);
    for (int m = 0; m < 8; m++) begin
      wr(A_MC, {5'h01, m[2:0]});
      idle(3);
      chk_bit("power", m != 0 && m != 7, power);
      chk_bit("digital", m == 7, digital);
      chk_byte("pin_oe", (m == 6) ? 8'h03 : 8'h00, {6'h00, oe});
      chk_bit("switch", m == 1 || m == 2 || m == 5, sw);
      rd("mode back", A_MC, {5'h01, m[2:0]});
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_polarity();
    set_raw(2'h1);
    for (int v = 0; v < 4; v++) begin
      wr(A_MC, {2'h0, v[1:0], 4'h6});
      idle(3);
      chk_byte("pins", {6'h00, 2'h1 ^ v[1:0]}, {6'h00, pin});
      rd("out bits", A_MC, {2'h1 ^ v[1:0], v[1:0], 4'h6});
    end
    $display("test polarity done");
  endtask : t_polarity
  task automatic t_change();
    wr(A_MC, 8'h06);
    idle(cmp_ctrl_pkg::BIAS_SETTLE_CYCLES);
    rd("ref read", A_MC, 8'h46);
    wr(A_FL, 8'h00);
    wr(A_EN, 8'h0d);
    rd("quiet flags", A_FL, 8'h00);
    set_raw(2'h0);
    idle(10);
    rd("set flags", A_FL, 8'h01);
    chk_bit("irq", 1'b1, link.irq);
    wr(A_FL, 8'h00);
    rd("held flags", A_FL, 8'h01);
    rd("reload", A_MC, 8'h06);
    wr(A_FL, 8'h00);
    rd("cleared", A_FL, 8'h00);
    chk_bit("irq off", 1'b0, link.irq);
    set_raw(2'h1);
    idle(10);
    wr(A_MC, 8'h06);
    wr(A_FL, 8'h00);
    rd("write ends", A_FL, 8'h00);
    wr(A_FL, 8'h02);
    rd("simulated", A_FL, 8'h02);
    $display("test change done");
  endtask : t_change
  task automatic t_enables();
    logic [3:0] en [4];
    logic [1:0] ex [4];
    en = '{4'he, 4'h6, 4'hc, 4'ha};
    ex = '{2'h3, 2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 4; i++) begin
      wr(A_EN, {4'h0, en[i]});
      idle(3);
      chk_bit("irq", ex[i][1], link.irq);
      chk_bit("wake", ex[i][0], link.wake);
      chk_bit("irq copy", ex[i][1], h_irq);
      chk_bit("wake copy", ex[i][0], h_wake);
    end
    wr(A_EN, 8'h00);
    wr(A_FL, 8'h00);
    $display("test enables done");
  endtask : t_enables
  task automatic t_gate();
    @(posedge i_clock);
    gpin <= 1'b1;
    idle(3);
    chk_bit("gate pin", 1'b1, link.timer1_gate);
    wr(A_GS, 8'h00);
    set_raw(2'h3);
    idle(3);
    chk_bit("gate direct", 1'b1, link.timer1_gate);
    wr(A_GS, 8'h01);
    @(negedge link.timer1_clk);
    set_raw(2'h1);
    idle(3);
    chk_bit("gate held", 1'b1, link.timer1_gate);
    idle(24);
    chk_bit("gate synced", 1'b0, link.timer1_gate);
    chk_bit("gate copy", 1'b0, h_gate);
    $display("test gate done");
  endtask : t_gate
  task automatic t_reset();
    wr(A_MC, 8'h35);
    wr(A_GS, 8'h01);
    wr(A_EN, 8'h0f);
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    rd("again mode", A_MC, 8'h00);
    rd("again gate", A_GS, 8'h02);
    rd("again flags", A_FL, 8'h00);
    rd("again enables", A_EN, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Free-running 100 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Cut a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    test_done();
  end

  // Reset for three cycles, then the scenarios in turn.
  initial begin
    mismatches  = 0;
    checks_done = 0;
    i_rst = 1'b1;
    req   = 1'b0;
    we    = 1'b0;
    adr   = 4'h0;
    wdat  = 8'h00;
    raw   = 2'h0;
    gpin  = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    t_modes();
    t_polarity();
    t_change();
    t_enables();
    t_gate();
    t_reset();
    test_done();
  end
endmodule : dual_comparator_control_tb
`default_nettype wire
